/* File: hw/sdr_register_bank.sv */
// Purpose: register bank of the delta-sigma converter module, two-wire slave
// Assumes: scl_in and sda_in are already synchronous to clock_in
// Notes:   result bytes have no reset; dac low byte is double buffered
`timescale 1ns/1ps
module sdr_register_bank
	import sdr_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h5a    // arbitrary bus address of the module
) (
	input  wire logic        clock_in,              // system clock, 100 MHz
	input  wire logic        sys_rst_in,            // async reset, active high
	input  wire logic        scl_in,                // serial clock from host
	input  wire logic        sda_in,                // serial data level on the wire
	output logic             sda_out,               // serial data driven level
	output logic             sda_oe_n_out,          // low while module pulls sda
	input  wire logic [23:0] result_in,             // filtered conversion result
	input  wire logic        result_valid_in,       // pulse, new result ready
	input  wire logic        timeout_event_in,      // pulse, serial timeout seen
	input  wire logic        osc_tick_in,           // pulse per oscillator clock
	output logic             common_ref_enable_out, // common-mode reference on
	output logic [6:0]       power_trim_out,        // performance trim bits
	output logic [1:0]       ref_attenuation_gain_out, // 00 x1, 01 x0.5, 10 x0.25
	output logic [7:0]       amp_gain_ctrl_out,     // amplifier gain register
	output logic [7:0]       amp_input_ctrl_out,    // amplifier input register
	output logic [7:0]       amp_channel_select_out, // amplifier channel register
	output logic [7:0]       conv_ctrl_first_out,   // conversion control 0
	output logic [7:0]       conv_ctrl_second_out,  // conversion control 1
	output logic [7:0]       conv_clock_select_out, // conversion clock select
	output logic [7:0]       conv_tuning_out,       // conversion tuning
	output logic [11:0]      dac_code_out,          // active dac code
	output logic             dac_ref_select_out,    // 0 supply rail, 1 common-mode ref
	output logic             dac_on_out,            // dac enable
	output logic [7:0]       serial_if_ctrl_out,    // serial interface control
	output logic [7:0]       serial_timeout_ctrl_out, // serial timeout control
	output logic             osc_enable_out,        // oscillator enable
	output logic             osc_stable_out         // oscillator stable flag
);
	import sdr_pkg::*;

	sdr_state_t st_r;
	sdr_state_t st_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic [7:0] sh_r;
	logic [7:0] sh_nxt;
	logic [7:0] ptr_r;
	logic [7:0] ptr_nxt;
	logic       rw_r;
	logic       rw_nxt;
	logic       nack_r;
	logic       nack_nxt;
	logic       drive_r;
	logic       drive_nxt;
	logic       scl_q_r;
	logic       sda_q_r;
	logic       wr_en;
	logic [7:0] rd_data;

	logic [7:0] ctl_r   [0:NUM_REGS-1];
	logic [7:0] ctl_nxt [0:NUM_REGS-1];
	logic [3:0] shadow_r;
	logic [3:0] shadow_nxt;
	logic [4:0] osc_cnt_r;
	logic [4:0] osc_cnt_nxt;
	logic       osc_stable_r;
	logic       osc_stable_nxt;
	logic [7:0] res_low_r;
	logic [7:0] res_mid_r;
	logic [7:0] res_high_r;

	wire start_cond = scl_in & scl_q_r & sda_q_r & ~sda_in;
	wire stop_cond  = scl_in & scl_q_r & ~sda_q_r & sda_in;
	wire scl_rise   = scl_in & ~scl_q_r;
	wire scl_fall   = ~scl_in & scl_q_r;

	// reads have no side effects; out-of-map and gap addresses give zero
	function automatic logic [7:0] read_byte(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == ADDR_RESULT_LOW) begin
			v = res_low_r;
		end else if (a == ADDR_RESULT_MID) begin
			v = res_mid_r;
		end else if (a == ADDR_RESULT_HIGH) begin
			v = res_high_r;
		end else if (a == ADDR_OSC) begin
			v = ctl_r[a[4:0]] & RD_MASK[a[4:0]];
			v[BIT_OSC_STABLE] = osc_stable_r;
		end else if (a < 8'(NUM_REGS)) begin
			v = ctl_r[a[4:0]] & RD_MASK[a[4:0]];
		end
		return v;
	endfunction

	// a process rather than an assign, so register file changes seen inside the function wake it
	always_comb begin
		rd_data = read_byte(ptr_r);
	end

	// serial slave: start, device byte, pointer byte, then data bytes with auto-increment
	always_comb begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		sh_nxt    = sh_r;
		ptr_nxt   = ptr_r;
		rw_nxt    = rw_r;
		nack_nxt  = nack_r;
		drive_nxt = drive_r;
		wr_en     = 1'b0;
		if (start_cond) begin
			st_nxt    = ST_DEV;
			cnt_nxt   = 4'd0;
			drive_nxt = 1'b0;
		end else if (stop_cond) begin
			st_nxt    = ST_IDLE;
			drive_nxt = 1'b0;
		end else begin
			case (st_r)
				ST_DEV, ST_PTR, ST_WR: begin
					if (scl_rise && cnt_r != BITS_PER_BYTE) begin
						sh_nxt  = {sh_r[6:0], sda_in};
						cnt_nxt = cnt_r + 4'd1;
					end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
						cnt_nxt = 4'd0;
						if (st_r == ST_DEV) begin
							if (sh_r[7:1] == DEV_ADDR) begin
								rw_nxt    = sh_r[0];
								drive_nxt = 1'b1;
								st_nxt    = ST_DEV_ACK;
							end else begin
								st_nxt = ST_IDLE;
							end
						end else if (st_r == ST_PTR) begin
							ptr_nxt   = sh_r;
							drive_nxt = 1'b1;
							st_nxt    = ST_PTR_ACK;
						end else begin
							wr_en     = 1'b1;
							ptr_nxt   = ptr_r + 8'd1;
							drive_nxt = 1'b1;
							st_nxt    = ST_WR_ACK;
						end
					end
				end
				ST_DEV_ACK, ST_PTR_ACK, ST_WR_ACK: begin
					if (scl_fall) begin
						drive_nxt = 1'b0;
						if (st_r == ST_DEV_ACK && rw_r) begin
							sh_nxt    = rd_data;
							drive_nxt = ~rd_data[7];
							cnt_nxt   = 4'd1;
							ptr_nxt   = ptr_r + 8'd1;
							st_nxt    = ST_RD;
						end else if (st_r == ST_DEV_ACK) begin
							st_nxt = ST_PTR;
						end else begin
							st_nxt = ST_WR;
						end
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						if (cnt_r == BITS_PER_BYTE) begin
							drive_nxt = 1'b0;
							st_nxt    = ST_RD_ACK;
						end else begin
							sh_nxt    = {sh_r[6:0], 1'b0};
							drive_nxt = ~sh_r[6];
							cnt_nxt   = cnt_r + 4'd1;
						end
					end
				end
				ST_RD_ACK: begin
					if (scl_rise) begin
						nack_nxt = sda_in;
					end else if (scl_fall) begin
						if (nack_r) begin
							st_nxt = ST_IDLE;
						end else begin
							sh_nxt    = rd_data;
							drive_nxt = ~rd_data[7];
							cnt_nxt   = 4'd1;
							ptr_nxt   = ptr_r + 8'd1;
							st_nxt    = ST_RD;
						end
					end
				end
				default: begin
					st_nxt = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_r    <= ST_IDLE;
			cnt_r   <= 4'd0;
			sh_r    <= 8'h00;
			ptr_r   <= 8'h00;
			rw_r    <= 1'b0;
			nack_r  <= 1'b0;
			drive_r <= 1'b0;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			sh_r    <= sh_nxt;
			ptr_r   <= ptr_nxt;
			rw_r    <= rw_nxt;
			nack_r  <= nack_nxt;
			drive_r <= drive_nxt;
			scl_q_r <= scl_in;
			sda_q_r <= sda_in;
		end
	end

	// register file; writes land on the falling scl edge after the eighth data bit
	always_comb begin
		logic [4:0] idx;
		logic       in_map;
		idx        = ptr_r[4:0];
		in_map     = (ptr_r < 8'(NUM_REGS)) && (ptr_r != ADDR_GAP);
		shadow_nxt = shadow_r;
		for (int i = 0; i < NUM_REGS; i++) begin
			ctl_nxt[i] = ctl_r[i];
		end
		if (wr_en && in_map) begin
			if (ptr_r == ADDR_DAC_LOW) begin
				shadow_nxt = sh_r[3:0];
			end else begin
				ctl_nxt[idx] = sh_r & WR_MASK[idx];
				if (ptr_r == ADDR_DAC_HIGH) begin
					ctl_nxt[ADDR_DAC_LOW[4:0]] = {4'h0, shadow_r};
				end
			end
		end
		// hardware-set flags: writing zero clears, a same-cycle event wins
		ctl_nxt[ADDR_CONV_SECOND[4:0]][BIT_EOC] = result_valid_in |
			(ctl_r[ADDR_CONV_SECOND[4:0]][BIT_EOC] &
			~(wr_en && ptr_r == ADDR_CONV_SECOND && !sh_r[BIT_EOC]));
		ctl_nxt[ADDR_TIMEOUT[4:0]][BIT_TIMEOUT_FLAG] = timeout_event_in |
			(ctl_r[ADDR_TIMEOUT[4:0]][BIT_TIMEOUT_FLAG] &
			~(wr_en && ptr_r == ADDR_TIMEOUT && !sh_r[BIT_TIMEOUT_FLAG]));
		// settle counter restarts whenever the oscillator is switched off
		osc_cnt_nxt = osc_cnt_r;
		if (!ctl_r[ADDR_OSC[4:0]][BIT_OSC_EN]) begin
			osc_cnt_nxt = 5'd0;
		end else if (osc_tick_in && osc_cnt_r != OSC_SETTLE_TICKS) begin
			osc_cnt_nxt = osc_cnt_r + 5'd1;
		end
		// next enable, so clearing the enable drops the flag in that same cycle
		osc_stable_nxt = ctl_nxt[ADDR_OSC[4:0]][BIT_OSC_EN] &&
			(osc_cnt_nxt == OSC_SETTLE_TICKS);
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				ctl_r[i] <= RST_VAL[i];
			end
			shadow_r     <= 4'h0;
			osc_cnt_r    <= 5'd0;
			osc_stable_r <= 1'b0;
		end else begin
			for (int i = 0; i < NUM_REGS; i++) begin
				ctl_r[i] <= ctl_nxt[i];
			end
			shadow_r     <= shadow_nxt;
			osc_cnt_r    <= osc_cnt_nxt;
			osc_stable_r <= osc_stable_nxt;
		end
	end

	// no reset here on purpose: contents are unknown until the first result
	always_ff @(posedge clock_in) begin
		if (result_valid_in) begin
			res_low_r  <= result_in[7:0];
			res_mid_r  <= result_in[15:8];
			res_high_r <= result_in[23:16];
		end
	end

	assign sda_out                  = 1'b0;
	assign sda_oe_n_out             = ~drive_r;
	assign common_ref_enable_out    = ctl_r[ADDR_POWER[4:0]][BIT_COMMON_REF];
	assign power_trim_out           = ctl_r[ADDR_POWER[4:0]][6:0];
	assign ref_attenuation_gain_out = ctl_r[ADDR_AMP_GAIN[4:0]][REF_GAIN_LSB+:2];
	assign amp_gain_ctrl_out        = ctl_r[ADDR_AMP_GAIN[4:0]];
	assign amp_input_ctrl_out       = ctl_r[ADDR_AMP_INPUT[4:0]];
	assign amp_channel_select_out   = ctl_r[ADDR_AMP_CHANNEL[4:0]];
	assign conv_ctrl_first_out      = ctl_r[ADDR_CONV_FIRST[4:0]];
	assign conv_ctrl_second_out     = ctl_r[ADDR_CONV_SECOND[4:0]];
	assign conv_clock_select_out    = ctl_r[ADDR_CONV_CLOCK[4:0]];
	assign conv_tuning_out          = ctl_r[ADDR_TUNING[4:0]];
	assign dac_code_out             = {ctl_r[ADDR_DAC_HIGH[4:0]],
		ctl_r[ADDR_DAC_LOW[4:0]][3:0]};
	assign dac_ref_select_out       = ctl_r[ADDR_DAC_CTRL[4:0]][BIT_DAC_REF];
	assign dac_on_out               = ctl_r[ADDR_DAC_CTRL[4:0]][BIT_DAC_ON];
	assign serial_if_ctrl_out       = ctl_r[ADDR_SERIAL[4:0]];
	assign serial_timeout_ctrl_out  = ctl_r[ADDR_TIMEOUT[4:0]];
	assign osc_enable_out           = ctl_r[ADDR_OSC[4:0]][BIT_OSC_EN];
	assign osc_stable_out           = osc_stable_r;

endmodule

/* File: hw/sdr_pkg.sv */
// Purpose: shared constants and types of the converter register bank
// Assumes: byte-wide registers on a two-wire serial bus, one system clock
// Notes:   masks and reset values are per address, indexed by register address
package sdr_pkg;

	localparam int         NUM_REGS         = 18;
	localparam logic [7:0] ADDR_POWER       = 8'h00;
	localparam logic [7:0] ADDR_AMP_GAIN    = 8'h01;
	localparam logic [7:0] ADDR_AMP_INPUT   = 8'h02;
	localparam logic [7:0] ADDR_AMP_CHANNEL = 8'h03;
	localparam logic [7:0] ADDR_RESULT_LOW  = 8'h04;
	localparam logic [7:0] ADDR_RESULT_MID  = 8'h05;
	localparam logic [7:0] ADDR_RESULT_HIGH = 8'h06;
	localparam logic [7:0] ADDR_CONV_FIRST  = 8'h07;
	localparam logic [7:0] ADDR_CONV_SECOND = 8'h08;
	localparam logic [7:0] ADDR_CONV_CLOCK  = 8'h09;
	localparam logic [7:0] ADDR_TUNING      = 8'h0a;
	localparam logic [7:0] ADDR_DAC_HIGH    = 8'h0b;
	localparam logic [7:0] ADDR_DAC_LOW     = 8'h0c;
	localparam logic [7:0] ADDR_DAC_CTRL    = 8'h0d;
	localparam logic [7:0] ADDR_SERIAL      = 8'h0e;
	localparam logic [7:0] ADDR_GAP         = 8'h0f;
	localparam logic [7:0] ADDR_TIMEOUT     = 8'h10;
	localparam logic [7:0] ADDR_OSC         = 8'h11;

	// power-on values, writable bits and readable bits per address
	localparam logic [7:0] RST_VAL [0:17] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h20, 8'h00, 8'h00, 8'he4, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
	localparam logic [7:0] WR_MASK [0:17] = '{8'hff, 8'h7f, 8'h7e, 8'h3f, 8'h00, 8'h00,
		8'h00, 8'hff, 8'hfc, 8'h1f, 8'hff, 8'hff, 8'h0f, 8'hc0, 8'h8c, 8'h00, 8'hbf, 8'h05};
	localparam logic [7:0] RD_MASK [0:17] = '{8'hff, 8'h7f, 8'h7e, 8'h3f, 8'hff, 8'hff,
		8'hff, 8'hff, 8'hfe, 8'h1f, 8'hff, 8'hff, 8'h0f, 8'hc0, 8'h8c, 8'h00, 8'hff, 8'h07};

	localparam int BIT_COMMON_REF   = 7;
	localparam int REF_GAIN_LSB     = 5;
	localparam int BIT_DAC_ON       = 7;
	localparam int BIT_DAC_REF      = 6;
	localparam int BIT_EOC          = 1;
	localparam int BIT_TIMEOUT_FLAG = 6;
	localparam int BIT_OSC_STABLE   = 1;
	localparam int BIT_OSC_EN       = 0;

	localparam logic [4:0] OSC_SETTLE_TICKS = 5'd16;
	localparam logic [3:0] BITS_PER_BYTE    = 4'd8;

	typedef enum logic [8:0] {
		ST_IDLE    = 9'b000000001,
		ST_DEV     = 9'b000000010,
		ST_DEV_ACK = 9'b000000100,
		ST_PTR     = 9'b000001000,
		ST_PTR_ACK = 9'b000010000,
		ST_WR      = 9'b000100000,
		ST_WR_ACK  = 9'b001000000,
		ST_RD      = 9'b010000000,
		ST_RD_ACK  = 9'b100000000
	} sdr_state_t;

endpackage

/* File: bench/sdr_register_bank_monitor.sv */
// Purpose: port-level assertions for the converter register bank
// Assumes: single clock domain, async active-high reset
// Notes:   tick counter mirrors the oscillator settle count
`timescale 1ns/1ps
module sdr_register_bank_monitor (
	input  wire logic        clock_in,                 // clock
	input  wire logic        sys_rst_in,               // reset
	input  wire logic        scl_in,                   // bus clock
	input  wire logic        osc_tick_in,              // osc tick
	input  wire logic        sda_out,                  // sda level
	input  wire logic        sda_oe_n_out,             // sda enable
	input  wire logic        common_ref_enable_out,    // ref on
	input  wire logic [1:0]  ref_attenuation_gain_out, // ref gain
	input  wire logic [7:0]  amp_gain_ctrl_out,        // reg 01h
	input  wire logic [7:0]  amp_input_ctrl_out,       // reg 02h
	input  wire logic [7:0]  amp_channel_select_out,   // reg 03h
	input  wire logic [7:0]  conv_ctrl_first_out,      // reg 07h
	input  wire logic [7:0]  conv_clock_select_out,    // reg 09h
	input  wire logic [7:0]  conv_tuning_out,          // reg 0ah
	input  wire logic [11:0] dac_code_out,             // dac code
	input  wire logic        dac_on_out,               // dac on
	input  wire logic        osc_enable_out,           // osc on
	input  wire logic        osc_stable_out            // osc stable
);
	logic [4:0] tick_cnt_r;
	logic [4:0] tick_cnt_nxt;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	// saturates so a long-stable oscillator does not wrap the count
	always_comb begin
		tick_cnt_nxt = tick_cnt_r;
		if (!osc_enable_out) tick_cnt_nxt = 5'h00;
		else if (osc_tick_in && tick_cnt_r != 5'h10) tick_cnt_nxt = tick_cnt_r + 5'h01;
	end
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) tick_cnt_r <= 5'h00;
		else tick_cnt_r <= tick_cnt_nxt;
	end
	AST_OPEN_DRAIN: assert property (!sda_oe_n_out |-> !sda_out)
		else $error("sda driven high");
	AST_SDA_CHANGE: assert property ($changed(sda_oe_n_out) |-> !scl_in)
		else $error("sda moved while scl high");
	AST_RESET_VALS: assert property ($fell(sys_rst_in) |-> conv_ctrl_first_out == 8'h20 &&
		conv_tuning_out == 8'he4 && dac_code_out == 12'h000 && !dac_on_out && osc_enable_out)
		else $error("bad reset value");
	AST_GAIN_MIRROR: assert property (ref_attenuation_gain_out == amp_gain_ctrl_out[6:5])
		else $error("gain field mismatch");
	AST_RESERVED_BITS: assert property (!amp_gain_ctrl_out[7] && !amp_input_ctrl_out[7] &&
		!amp_input_ctrl_out[0] && amp_channel_select_out[7:6] == 2'h0 &&
		conv_clock_select_out[7:5] == 3'h0) else $error("unimplemented bit set");
	AST_BUS_ONLY: assert property ($changed({dac_code_out, dac_on_out, common_ref_enable_out})
		|-> !scl_in && !$past(scl_in)) else $error("control changed outside bus write");
	AST_OSC_COUNT: assert property (osc_stable_out |-> osc_enable_out && tick_cnt_r == 5'h10)
		else $error("stable before 16 ticks");
	AST_OSC_STAYS: assert property (osc_stable_out && osc_enable_out |=>
		osc_stable_out || !osc_enable_out) else $error("stable flag dropped");
	cover property ($rose(osc_stable_out));
	cover property ($fell(sda_oe_n_out));
	cover property ($changed(dac_code_out));
endmodule
bind sdr_register_bank sdr_register_bank_monitor u_mon (
	.clock_in                 (clock_in),
	.sys_rst_in               (sys_rst_in),
	.scl_in                   (scl_in),
	.osc_tick_in              (osc_tick_in),
	.sda_out                  (sda_out),
	.sda_oe_n_out             (sda_oe_n_out),
	.common_ref_enable_out    (common_ref_enable_out),
	.ref_attenuation_gain_out (ref_attenuation_gain_out),
	.amp_gain_ctrl_out        (amp_gain_ctrl_out),
	.amp_input_ctrl_out       (amp_input_ctrl_out),
	.amp_channel_select_out   (amp_channel_select_out),
	.conv_ctrl_first_out      (conv_ctrl_first_out),
	.conv_clock_select_out    (conv_clock_select_out),
	.conv_tuning_out          (conv_tuning_out),
	.dac_code_out             (dac_code_out),
	.dac_on_out               (dac_on_out),
	.osc_enable_out           (osc_enable_out),
	.osc_stable_out           (osc_stable_out)
);

/* File: bench/sdr_host_model.sv */
// Purpose: host side of the two-wire register bus
// Assumes: sda has a pull-up; per data bit scl stays high four system clocks and low eight
// Notes:   signals change only just after a rising clock edge
`timescale 1ns/1ps
module sdr_host_model #(
	parameter logic [6:0] DEV = 7'h5a // bank bus address, arbitrary
) (
	input  wire logic clock_in, // system clock
	input  wire logic sda_in,   // resolved sda wire
	output logic      scl_out,  // serial clock, idles high
	output logic      sda_out   // 0 pulls sda low, 1 releases
);
	logic       a;
	logic [7:0] q;
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic ph();
		repeat (4) @(posedge clock_in);
	endtask
	// data moves only with scl low, so no false start or stop is seen
	task automatic bio(input logic b, output logic r);
		sda_out <= b;
		ph();
		scl_out <= 1'b1;
		ph();
		r = sda_in;
		scl_out <= 1'b0;
		ph();
	endtask
	task automatic xb(input logic [7:0] d, input logic last, output logic [7:0] r,
		output logic ack);
		for (int i = 7; i >= 0; i--) bio(d[i], r[i]);
		bio(last, a);
		ack = !a;
	endtask
	task automatic sta();
		sda_out <= 1'b1;
		ph();
		scl_out <= 1'b1;
		ph();
		sda_out <= 1'b0;
		ph();
		scl_out <= 1'b0;
		ph();
	endtask
	task automatic sto();
		sda_out <= 1'b0;
		ph();
		scl_out <= 1'b1;
		ph();
		sda_out <= 1'b1;
		ph();
	endtask
	task automatic wr(input logic [6:0] dv, input logic [7:0] ad, input logic [7:0] d,
		output logic ok);
		logic k1, k2, k3;
		sta();
		xb({dv, 1'b0}, 1'b1, q, k1);
		xb(ad, 1'b1, q, k2);
		xb(d, 1'b1, q, k3);
		sto();
		ok = k1 & k2 & k3;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [7:0] d);
		sta();
		xb({DEV, 1'b0}, 1'b1, q, a);
		xb(ad, 1'b1, q, a);
		sta();
		xb({DEV, 1'b1}, 1'b1, q, a);
		xb(8'hff, 1'b1, d, a);
		sto();
	endtask
endmodule

/* File: bench/testbench.sv */
// Purpose: self-checking bench of the converter register bank
// Assumes: host model drives the bus; bench drives result and tick pulses
// Notes:   timeout event pulses once together with the first result
`timescale 1ns/1ps
module testbench;
	import sdr_pkg::*;
	localparam logic [6:0] DEV = 7'h5a; // arbitrary bus address
	logic        clock_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic [23:0] res = 24'h000000;
	logic        res_v = 1'b0;
	logic        tick = 1'b0;
	logic        tmo_ev = 1'b0;
	int          errors = 0;
	int          n_checks = 0;
	wire         scl, host_sda, sda_w, d_sda, d_oe_n, cref, dac_on, dac_ref, osc_en, osc_st;
	wire  [1:0]  gain;
	wire  [11:0] dac_code;
	wire  [6:0]  trim;
	wire  [7:0]  conv2;
	wire  [7:0]  tmo_ctl;
	assign sda_w = host_sda & (d_oe_n | d_sda);
	always #5 clock_in = ~clock_in;
	sdr_host_model #(.DEV(DEV)) host (.clock_in(clock_in), .sda_in(sda_w), .scl_out(scl),
		.sda_out(host_sda));
	sdr_register_bank #(.DEV_ADDR(DEV)) DUT (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.scl_in(scl), .sda_in(sda_w), .sda_out(d_sda), .sda_oe_n_out(d_oe_n),
		.result_in(res), .result_valid_in(res_v), .timeout_event_in(tmo_ev),
		.osc_tick_in(tick), .common_ref_enable_out(cref), .power_trim_out(trim),
		.ref_attenuation_gain_out(gain), .amp_gain_ctrl_out(), .amp_input_ctrl_out(),
		.amp_channel_select_out(), .conv_ctrl_first_out(), .conv_ctrl_second_out(conv2),
		.conv_clock_select_out(), .conv_tuning_out(), .dac_code_out(dac_code),
		.dac_ref_select_out(dac_ref), .dac_on_out(dac_on), .serial_if_ctrl_out(),
		.serial_timeout_ctrl_out(tmo_ctl), .osc_enable_out(osc_en), .osc_stable_out(osc_st));
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		host.wr(DEV, a, d, ok);
		chk(ok, 1'b1);
	endtask
	task automatic r(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		host.rd(a, q);
		chk(q, e);
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic t_reset();
		// result bytes skipped: they hold no defined value yet
		for (int a = 0; a <= 18; a++) begin
			if (a < 4 || a > 6) r(a[7:0], a < NUM_REGS ? RST_VAL[a] : 8'h00);
		end
		chk({dac_code, dac_on, dac_ref, cref, osc_en, osc_st}, 17'h00002);
		$display("t_reset done");
	endtask
	task automatic t_write();
		logic ok;
		for (int a = 0; a <= 18; a++) begin
			if (a < 4 || a > 6) begin
				w(a[7:0], 8'hff);
				r(a[7:0], (a == 12 || a >= NUM_REGS) ? 8'h00 : WR_MASK[a]);
			end
		end
		chk({cref, gain, dac_on, dac_ref}, 5'h1f);
		chk({trim, conv2, tmo_ctl}, 23'h7ffcbf);
		w(8'h00, 8'h00);
		w(8'h0d, 8'h40);
		chk({cref, dac_on, dac_ref}, 3'h1);
		host.wr(DEV ^ 7'h01, 8'h00, 8'hff, ok);
		chk({ok, cref}, 2'h0);
		$display("t_write done");
	endtask
	task automatic t_dac();
		w(8'h0c, 8'ha5);
		chk(dac_code, 12'hff0);
		w(8'h0b, 8'h3c);
		chk(dac_code, 12'h3c5);
		r(8'h0c, 8'h05);
		for (int g = 0; g < 3; g++) begin
			w(8'h01, 8'(g << 5));
			chk(gain, g[1:0]);
		end
		$display("t_dac done");
	endtask
	task automatic t_result();
		@(posedge clock_in);
		res <= 24'h123456;
		res_v <= 1'b1;
		tmo_ev <= 1'b1;
		@(posedge clock_in);
		res_v <= 1'b0;
		tmo_ev <= 1'b0;
		r(8'h04, 8'h56);
		r(8'h05, 8'h34);
		r(8'h06, 8'h12);
		r(8'h08, 8'hfe);
		chk(tmo_ctl, 8'hff);
		w(8'h08, 8'h00);
		chk(conv2, 8'h00);
		w(8'h04, 8'h00);
		r(8'h04, 8'h56);
		$display("t_result done");
	endtask
	task automatic t_osc();
		for (int i = 0; i < 16; i++) begin
			#1;
			chk(osc_st, 1'b0);
			@(posedge clock_in);
			tick <= 1'b1;
			@(posedge clock_in);
			tick <= 1'b0;
		end
		repeat (2) @(posedge clock_in);
		#1;
		chk(osc_st, 1'b1);
		r(8'h11, 8'h07);
		w(8'h11, 8'h00);
		chk({osc_en, osc_st}, 2'h0);
		$display("t_osc done");
	endtask
	initial begin
		repeat (5) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		repeat (2) @(posedge clock_in);
		t_reset();
		t_write();
		t_dac();
		t_result();
		t_osc();
		stop_test();
	end
	// about 28k cycles expected; cut off at 100k
	initial begin
		#1000000;
		errors++;
		stop_test();
	end
endmodule
